// [sbdc_pkg.sv]
`default_nettype none

package sbdc_pkg;

  // ==========================================================
  // sizes
  localparam int PHASES = 3;
  localparam int CUR_W = 16;
  localparam int GROUPS = 8;
  localparam int GROUP_WORDS = 3;
  localparam int TAP_FRAC = 8;
  localparam int SLOPE_FRAC = 7;

  // ==========================================================
  // register map, byte addresses
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam int GROUP_AREA_BIT = 7;
  localparam int GROUP_IDX_LSB = 4;
  localparam int GROUP_WORD_LSB = 2;

  // ==========================================================
  // control and status fields
  localparam int CTRL_GROUP_LSB = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam int ST_OPERATE = 0;
  localparam int ST_DIFF_TRIP_LSB = 1;
  localparam int ST_TX_TRIP_LSB = 4;
  localparam int ST_RX_TRIP_LSB = 7;
  localparam int ST_GROUP_LSB = 10;
  localparam int ST_SWITCH_OPEN = 13;
  localparam int ST_TRIGGER = 14;
  localparam int ST_INHIBIT = 15;

  // ==========================================================
  // per-group setting words
  localparam int W0_DIFF_EN = 0;
  localparam int W0_STUB_EN = 1;
  localparam int W0_SEND_EN = 2;
  localparam int W0_TRIG_ON = 3;
  localparam int W0_PICKUP_LSB = 16;
  localparam int W1_TAP1_LSB = 0;
  localparam int W1_TAP2_LSB = 16;
  localparam int W2_SLOPE1_LSB = 0;
  localparam int W2_SLOPE2_LSB = 8;
  localparam int W2_BREAK_LSB = 16;
  localparam logic [31:0] W0_RST = 32'h0040_0001;
  localparam logic [31:0] W1_RST = 32'h0100_0100;
  localparam logic [31:0] W2_RST = 32'h0200_260D;

  // ==========================================================
  // bus handshake states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_READ = 2'b01,
    BUS_ACK = 2'b10
  } sbdc_bus_state_t;

  // requested group 1..8 selects it, anything else falls back to group 1
  function automatic logic [2:0] group_index(input logic [3:0] req);
    if (req >= 4'h1 && req <= 4'h8)
    begin
      return 3'(req - 4'h1);
    end
    return 3'h0;
  endfunction : group_index

endpackage : sbdc_pkg

`default_nettype wire

// [sbdc_pin_sync.sv]
`default_nettype none

// ============================================================
// three-stage pin synchroniser with agreement filter
module sbdc_pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [WIDTH-1:0] i_pin,
  output logic [WIDTH-1:0] o_level
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] filt;
  } sbdc_sync_state_t;

  sbdc_sync_state_t s_q;
  sbdc_sync_state_t s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.s1 = i_pin;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    // a change counts only once stages two and three agree
    s_d.filt = ((s_q.s2 ~^ s_q.s3) & s_q.s3) | ((s_q.s2 ^ s_q.s3) & s_q.filt);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_level = s_q.filt;

endmodule : sbdc_pin_sync

`default_nettype wire

// [sbdc_setting_mem.sv]
`default_nettype none

// ============================================================
// setting group store: byte writes, two registered read ports
module sbdc_setting_mem #(
  parameter int DEPTH = 8,
  parameter int WORDS = 3,
  parameter logic [WORDS*32-1:0] RESET_ENTRY = '0
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_wr_en,
  input wire logic [$clog2(DEPTH)-1:0] i_wr_idx,
  input wire logic [1:0] i_wr_word,
  input wire logic [3:0] i_wr_be,
  input wire logic [31:0] i_wr_data,
  input wire logic [$clog2(DEPTH)-1:0] i_bus_idx,
  input wire logic [1:0] i_bus_word,
  output logic [31:0] o_bus_rdata,
  input wire logic [$clog2(DEPTH)-1:0] i_act_idx,
  output logic [WORDS*32-1:0] o_act_data
);

  typedef struct packed {
    logic [DEPTH-1:0][WORDS*32-1:0] mem;
    logic [31:0] bus_rd;
    logic [WORDS*32-1:0] act_rd;
  } sbdc_mem_state_t;

  sbdc_mem_state_t s_q;
  sbdc_mem_state_t s_d;

  always_comb
  begin
    s_d = s_q;
    for (int w = 0; w < WORDS; w++)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (i_wr_en && i_wr_word == 2'(w) && i_wr_be[b])
        begin
          s_d.mem[i_wr_idx][w*32+b*8 +: 8] = i_wr_data[b*8 +: 8];
        end
      end
    end
    // words past the last one read as zero
    s_d.bus_rd = '0;
    for (int w = 0; w < WORDS; w++)
    begin
      if (i_bus_word == 2'(w))
      begin
        s_d.bus_rd = s_q.mem[i_bus_idx][w*32 +: 32];
      end
    end
    s_d.act_rd = s_q.mem[i_act_idx];
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      s_q.mem <= {DEPTH{RESET_ENTRY}};
      s_q.bus_rd <= '0;
      s_q.act_rd <= RESET_ENTRY;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_bus_rdata = s_q.bus_rd;
  assign o_act_data = s_q.act_rd;

endmodule : sbdc_setting_mem

`default_nettype wire

// [sbdc_stub_diff.sv]
// Chosen here: the placing of the registers and register access over Avalon-MM.
`default_nettype none

// ============================================================
// differential supervision with isolated-bay mode
module sbdc_stub_diff #(
  parameter int PHASES = sbdc_pkg::PHASES,
  parameter int CUR_W = sbdc_pkg::CUR_W
) (
  input wire logic I_REF_CLK,
  input wire logic I_RESET,
  // avalon-mm slave
  input wire logic [7:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  // operands from outside logic
  input wire logic I_LINE_SWITCH_OPEN,
  input wire logic I_STUB_TRIGGER,
  input wire logic I_DIFF_INHIBIT,
  input wire logic I_EXTRA_REMOTE_TRIP_KEY,
  input wire logic [PHASES-1:0] I_RX_REMOTE_TRIP_COMMAND,
  // sampled currents, one signed word per phase
  input wire logic [PHASES*CUR_W-1:0] I_LOCAL_CURRENT,
  input wire logic [PHASES*CUR_W-1:0] I_CH1_CURRENT,
  input wire logic [PHASES*CUR_W-1:0] I_CH2_CURRENT,
  // results
  output logic O_STUB_OPERATE,
  output logic [PHASES*CUR_W-1:0] O_TX_CURRENT,
  output logic [PHASES*CUR_W-1:0] O_CH1_SCALED,
  output logic [PHASES*CUR_W-1:0] O_CH2_SCALED,
  output logic [PHASES-1:0] O_DIFF_TRIP,
  output logic [PHASES-1:0] O_TX_REMOTE_TRIP_COMMAND,
  output logic [PHASES-1:0] O_RX_TRIP_ACCEPTED,
  output logic [2:0] O_ACTIVE_GROUP
);

  localparam int ENTRY_W = sbdc_pkg::GROUP_WORDS * 32;
  localparam logic [ENTRY_W-1:0] ENTRY_RST = {sbdc_pkg::W2_RST, sbdc_pkg::W1_RST,
                                              sbdc_pkg::W0_RST};

  // ==========================================================
  // state
  typedef struct packed {
    sbdc_pkg::sbdc_bus_state_t bus;
    logic wait_req;
    logic [31:0] rdata;
    logic [7:0] addr;
    logic [3:0] group_req;
    logic operate;
    logic [PHASES-1:0] diff_trip;
    logic [PHASES-1:0] tx_trip;
    logic [PHASES-1:0] rx_ok;
    logic [PHASES*CUR_W-1:0] tx_cur;
    logic [PHASES*CUR_W-1:0] ch1_s;
    logic [PHASES*CUR_W-1:0] ch2_s;
    logic [2:0] group;
  } sbdc_top_state_t;

  sbdc_top_state_t s_q;
  sbdc_top_state_t s_d;

  // ==========================================================
  // pin synchronisers
  logic [PHASES+3:0] pins_raw;
  logic [PHASES+3:0] pins;
  logic sw_open;
  logic trig_in;
  logic inhibit;
  logic extra_key;
  logic [PHASES-1:0] rx_cmd;

  assign pins_raw = {I_RX_REMOTE_TRIP_COMMAND, I_EXTRA_REMOTE_TRIP_KEY, I_DIFF_INHIBIT,
                     I_STUB_TRIGGER, I_LINE_SWITCH_OPEN};
  assign sw_open = pins[0];
  assign trig_in = pins[1];
  assign inhibit = pins[2];
  assign extra_key = pins[3];
  assign rx_cmd = pins[PHASES+3:4];

  sbdc_pin_sync #(
    .WIDTH(PHASES + 4)
  ) u_sync (
    .i_clk(I_REF_CLK),
    .i_reset(I_RESET),
    .i_pin(pins_raw),
    .o_level(pins)
  );

  // ==========================================================
  // setting groups
  logic grp_area;
  logic mem_wr;
  logic [31:0] mem_bus_rdata;
  logic [ENTRY_W-1:0] act;
  logic [2:0] act_idx;

  assign grp_area = I_AVS_ADDRESS[sbdc_pkg::GROUP_AREA_BIT];
  // writes land in the idle cycle, while waitrequest still holds the master
  assign mem_wr = (s_q.bus == sbdc_pkg::BUS_IDLE) && I_AVS_WRITE && grp_area;
  assign act_idx = sbdc_pkg::group_index(s_q.group_req);

  sbdc_setting_mem #(
    .DEPTH(sbdc_pkg::GROUPS),
    .WORDS(sbdc_pkg::GROUP_WORDS),
    .RESET_ENTRY(ENTRY_RST)
  ) u_mem (
    .i_clk(I_REF_CLK),
    .i_reset(I_RESET),
    .i_wr_en(mem_wr),
    .i_wr_idx(I_AVS_ADDRESS[sbdc_pkg::GROUP_IDX_LSB +: 3]),
    .i_wr_word(I_AVS_ADDRESS[sbdc_pkg::GROUP_WORD_LSB +: 2]),
    .i_wr_be(I_AVS_BYTEENABLE),
    .i_wr_data(I_AVS_WRITEDATA),
    .i_bus_idx(I_AVS_ADDRESS[sbdc_pkg::GROUP_IDX_LSB +: 3]),
    .i_bus_word(I_AVS_ADDRESS[sbdc_pkg::GROUP_WORD_LSB +: 2]),
    .o_bus_rdata(mem_bus_rdata),
    .i_act_idx(act_idx),
    .o_act_data(act)
  );

  // ==========================================================
  // active settings
  logic diff_en;
  logic stub_en;
  logic send_en;
  logic trig_on;
  logic [15:0] pickup;
  logic [15:0] tap1;
  logic [15:0] tap2;
  logic [7:0] slope1;
  logic [7:0] slope2;
  logic [15:0] brk;

  assign diff_en = act[sbdc_pkg::W0_DIFF_EN];
  assign stub_en = act[sbdc_pkg::W0_STUB_EN];
  assign send_en = act[sbdc_pkg::W0_SEND_EN];
  assign trig_on = act[sbdc_pkg::W0_TRIG_ON];
  assign pickup = act[sbdc_pkg::W0_PICKUP_LSB +: 16];
  assign tap1 = act[32 + sbdc_pkg::W1_TAP1_LSB +: 16];
  assign tap2 = act[32 + sbdc_pkg::W1_TAP2_LSB +: 16];
  assign slope1 = act[64 + sbdc_pkg::W2_SLOPE1_LSB +: 8];
  assign slope2 = act[64 + sbdc_pkg::W2_SLOPE2_LSB +: 8];
  assign brk = act[64 + sbdc_pkg::W2_BREAK_LSB +: 16];

  function automatic logic [17:0] mag(input logic signed [17:0] v);
    return v[17] ? 18'(-v) : 18'(v);
  endfunction : mag

  // ==========================================================
  // per-phase scaling and dual-slope comparison
  logic [PHASES-1:0] phase_op;
  logic [PHASES*CUR_W-1:0] ch1_scaled;
  logic [PHASES*CUR_W-1:0] ch2_scaled;

  for (genvar p = 0; p < PHASES; p++)
  begin : g_phase
    logic signed [CUR_W-1:0] loc;
    logic signed [CUR_W-1:0] r1;
    logic signed [CUR_W-1:0] r2;
    logic signed [32:0] m1;
    logic signed [32:0] m2;
    logic signed [CUR_W-1:0] s1;
    logic signed [CUR_W-1:0] s2;
    logic signed [17:0] dif;
    logic [17:0] dif_mag;
    logic [17:0] restr;
    logic [26:0] thr;
    logic [26:0] dif_sc;

    assign loc = I_LOCAL_CURRENT[p*CUR_W +: CUR_W];
    assign r1 = I_CH1_CURRENT[p*CUR_W +: CUR_W];
    assign r2 = I_CH2_CURRENT[p*CUR_W +: CUR_W];
    // remote currents brought to the local ct base; overflow wraps
    assign m1 = r1 * $signed({1'b0, tap1});
    assign m2 = r2 * $signed({1'b0, tap2});
    assign s1 = m1[sbdc_pkg::TAP_FRAC +: CUR_W];
    assign s2 = m2[sbdc_pkg::TAP_FRAC +: CUR_W];
    assign ch1_scaled[p*CUR_W +: CUR_W] = s1;
    assign ch2_scaled[p*CUR_W +: CUR_W] = s2;
    assign dif = 18'(loc) + 18'(s1) + 18'(s2);
    assign dif_mag = mag(dif);
    assign restr = mag(18'(loc)) + mag(18'(s1)) + mag(18'(s2));
    // second slope takes over above the breakpoint
    always_comb
    begin
      if (restr <= 18'(brk))
      begin
        thr = 27'(restr) * 27'(slope1);
      end
      else
      begin
        thr = 27'(brk) * 27'(slope1) + 27'(restr - 18'(brk)) * 27'(slope2);
      end
    end
    assign dif_sc = 27'({dif_mag, 7'h00});
    assign phase_op[p] = (dif_mag > 18'(pickup)) && (dif_sc > thr);
  end

  // ==========================================================
  // next state
  logic trig_eff;
  logic [31:0] status;

  // a forced-on trigger bypasses the pin, so with stub_en set operate follows the switch alone
  assign trig_eff = trig_on | trig_in;

  always_comb
  begin
    s_d = s_q;
    s_d.group = act_idx;

    // isolated-bay operate: all three conditions, drops when any one goes
    s_d.operate = stub_en && sw_open && trig_eff;
    s_d.diff_trip = phase_op & {PHASES{diff_en && !inhibit && !s_d.operate}};
    s_d.tx_trip = (s_d.diff_trip & {PHASES{send_en}}) | {PHASES{extra_key}};
    s_d.rx_ok = rx_cmd & {PHASES{!s_d.operate}};
    s_d.tx_cur = s_d.operate ? '0 : I_LOCAL_CURRENT;
    s_d.ch1_s = ch1_scaled;
    s_d.ch2_s = ch2_scaled;

    status = '0;
    status[sbdc_pkg::ST_OPERATE] = s_q.operate;
    status[sbdc_pkg::ST_DIFF_TRIP_LSB +: 3] = s_q.diff_trip;
    status[sbdc_pkg::ST_TX_TRIP_LSB +: 3] = s_q.tx_trip;
    status[sbdc_pkg::ST_RX_TRIP_LSB +: 3] = s_q.rx_ok;
    status[sbdc_pkg::ST_GROUP_LSB +: 3] = s_q.group;
    status[sbdc_pkg::ST_SWITCH_OPEN] = sw_open;
    status[sbdc_pkg::ST_TRIGGER] = trig_in;
    status[sbdc_pkg::ST_INHIBIT] = inhibit;

    case (s_q.bus)
      sbdc_pkg::BUS_IDLE:
      begin
        s_d.wait_req = 1'b1;
        if (I_AVS_WRITE)
        begin
          if (I_AVS_ADDRESS == sbdc_pkg::OFS_CTRL && I_AVS_BYTEENABLE[0])
          begin
            s_d.group_req = I_AVS_WRITEDATA[sbdc_pkg::CTRL_GROUP_LSB +: 4];
          end
          s_d.wait_req = 1'b0;
          s_d.bus = sbdc_pkg::BUS_ACK;
        end
        else if (I_AVS_READ)
        begin
          s_d.addr = I_AVS_ADDRESS;
          s_d.bus = sbdc_pkg::BUS_READ;
        end
      end
      sbdc_pkg::BUS_READ:
      begin
        // group words need the memory's registered read, one cycle on
        if (s_q.addr[sbdc_pkg::GROUP_AREA_BIT])
        begin
          s_d.rdata = mem_bus_rdata;
        end
        else if (s_q.addr == sbdc_pkg::OFS_CTRL)
        begin
          s_d.rdata = {28'h0000000, s_q.group_req};
        end
        else if (s_q.addr == sbdc_pkg::OFS_STATUS)
        begin
          s_d.rdata = status;
        end
        else
        begin
          s_d.rdata = 32'h0000_0000;
        end
        s_d.wait_req = 1'b0;
        s_d.bus = sbdc_pkg::BUS_ACK;
      end
      sbdc_pkg::BUS_ACK:
      begin
        s_d.wait_req = 1'b1;
        s_d.bus = sbdc_pkg::BUS_IDLE;
      end
      default:
      begin
        s_d.wait_req = 1'b1;
        s_d.bus = sbdc_pkg::BUS_IDLE;
      end
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RESET)
    begin
      s_q <= '0;
      s_q.bus <= sbdc_pkg::BUS_IDLE;
      s_q.wait_req <= 1'b1;
      s_q.group_req <= sbdc_pkg::CTRL_RST[3:0];
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign O_AVS_READDATA = s_q.rdata;
  assign O_AVS_WAITREQUEST = s_q.wait_req;
  assign O_STUB_OPERATE = s_q.operate;
  assign O_TX_CURRENT = s_q.tx_cur;
  assign O_CH1_SCALED = s_q.ch1_s;
  assign O_CH2_SCALED = s_q.ch2_s;
  assign O_DIFF_TRIP = s_q.diff_trip;
  assign O_TX_REMOTE_TRIP_COMMAND = s_q.tx_trip;
  assign O_RX_TRIP_ACCEPTED = s_q.rx_ok;
  assign O_ACTIVE_GROUP = s_q.group;

endmodule : sbdc_stub_diff

`default_nettype wire

// [sbdc_stub_diff_checker.sv]
`default_nettype none

// ==========================================================
// port-level checks of the isolated-bay supervision
module sbdc_stub_diff_checker #(
  parameter int PHASES = 3,
  parameter int CUR_W = 16
) (
  input wire logic I_REF_CLK,
  input wire logic I_RESET,
  input wire logic I_LINE_SWITCH_OPEN,
  input wire logic I_DIFF_INHIBIT,
  input wire logic I_EXTRA_REMOTE_TRIP_KEY,
  input wire logic [PHASES-1:0] I_RX_REMOTE_TRIP_COMMAND,
  input wire logic [PHASES*CUR_W-1:0] I_LOCAL_CURRENT,
  input wire logic O_STUB_OPERATE,
  input wire logic [PHASES*CUR_W-1:0] O_TX_CURRENT,
  input wire logic [PHASES-1:0] O_DIFF_TRIP,
  input wire logic [PHASES-1:0] O_TX_REMOTE_TRIP_COMMAND,
  input wire logic [PHASES-1:0] O_RX_TRIP_ACCEPTED
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (I_RESET);

  // ==========================================================
  // operate and its effects; a pin sampled at one edge shows at the outputs 5 edges on
  // (three sync stages, the agreement flop, then the output register)
  property p_tx_zero;
    O_STUB_OPERATE |-> O_TX_CURRENT == '0;
  endproperty
  a_tx_zero: assert property (p_tx_zero) else $error("tx current not zero in operate");
  property p_rx_block;
    O_STUB_OPERATE |-> O_RX_TRIP_ACCEPTED == '0;
  endproperty
  a_rx_block: assert property (p_rx_block) else $error("remote trip passed in operate");
  property p_diff_off;
    O_STUB_OPERATE |-> O_DIFF_TRIP == '0;
  endproperty
  a_diff_off: assert property (p_diff_off) else $error("diff trip during operate");
  property p_tx_pass;
    !O_STUB_OPERATE && !$past(I_RESET) |-> O_TX_CURRENT == $past(I_LOCAL_CURRENT);
  endproperty
  a_tx_pass: assert property (p_tx_pass) else $error("tx current not local");
  property p_op_rise;
    $rose(O_STUB_OPERATE) |-> $past(I_LINE_SWITCH_OPEN, 5);
  endproperty
  a_op_rise: assert property (p_op_rise) else $error("operate without open switch");
  property p_op_drop;
    $fell(I_LINE_SWITCH_OPEN) |-> ##5 !O_STUB_OPERATE;
  endproperty
  a_op_drop: assert property (p_op_drop) else $error("operate held after close");
  property p_key;
    I_EXTRA_REMOTE_TRIP_KEY [*5] |=> O_TX_REMOTE_TRIP_COMMAND == '1;
  endproperty
  a_key: assert property (p_key) else $error("key did not send all phases");
  property p_rx_pass;
    (O_RX_TRIP_ACCEPTED & ~$past(I_RX_REMOTE_TRIP_COMMAND, 5)) == '0;
  endproperty
  a_rx_pass: assert property (p_rx_pass) else $error("accepted trip never received");
  property p_inhibit;
    $past(I_DIFF_INHIBIT, 5) |-> O_DIFF_TRIP == '0;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("diff trip while inhibited");

  c_operate: cover property ($rose(O_STUB_OPERATE));
  c_diff: cover property (O_DIFF_TRIP != '0);
  c_key: cover property (O_TX_REMOTE_TRIP_COMMAND == '1);
endmodule : sbdc_stub_diff_checker

bind sbdc_stub_diff sbdc_stub_diff_checker #(.PHASES(PHASES), .CUR_W(CUR_W)) chk (
  .I_REF_CLK(I_REF_CLK),
  .I_RESET(I_RESET),
  .I_LINE_SWITCH_OPEN(I_LINE_SWITCH_OPEN),
  .I_DIFF_INHIBIT(I_DIFF_INHIBIT),
  .I_EXTRA_REMOTE_TRIP_KEY(I_EXTRA_REMOTE_TRIP_KEY),
  .I_RX_REMOTE_TRIP_COMMAND(I_RX_REMOTE_TRIP_COMMAND),
  .I_LOCAL_CURRENT(I_LOCAL_CURRENT),
  .O_STUB_OPERATE(O_STUB_OPERATE),
  .O_TX_CURRENT(O_TX_CURRENT),
  .O_DIFF_TRIP(O_DIFF_TRIP),
  .O_TX_REMOTE_TRIP_COMMAND(O_TX_REMOTE_TRIP_COMMAND),
  .O_RX_TRIP_ACCEPTED(O_RX_TRIP_ACCEPTED)
);

`default_nettype wire

// [sbdc_remote_model.sv]
`default_nettype none

// ==========================================================
// remote terminals: channel currents and trips, LAT edges late
module sbdc_remote_model #(
  parameter int LAT = 2
) (
  input wire logic i_clk,
  input wire logic [47:0] i_ch1,
  input wire logic [47:0] i_ch2,
  input wire logic [2:0] i_trip,
  output logic [47:0] o_ch1,
  output logic [47:0] o_ch2,
  output logic [2:0] o_rx_trip
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [98:0] pipe_q [LAT];

  // link delay; trips stay per-phase levels as sent
  always_ff @(posedge i_clk)
  begin
    pipe_q[0] <= {i_ch1, i_ch2, i_trip};
    for (int i = 1; i < LAT; i++)
      pipe_q[i] <= pipe_q[i-1];
  end
  assign {o_ch1, o_ch2, o_rx_trip} = pipe_q[LAT-1];
endmodule : sbdc_remote_model

`default_nettype wire

// [sbdc_stub_diff_tb.sv]
`default_nettype none

// ==========================================================
// self-checking bench
module sbdc_stub_diff_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0;
  logic rst = 1;
  logic [7:0] adr = 8'h00;
  logic rd_s = 0;
  logic wr_s = 0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata;
  logic waitreq;
  logic sw = 0;
  logic trig = 0;
  logic inh = 0;
  logic key = 0;
  logic [47:0] loc = 48'h0;
  logic [47:0] rm_ch1 = 48'h0;
  logic [47:0] rm_ch2 = 48'h0;
  logic [2:0] rm_trip = 3'h0;
  logic [47:0] ch1, ch2, txc, s1, s2;
  logic [2:0] rx, dtrip, ttrip, racc, grp;
  logic op;
  logic [31:0] q;
  int n_fail = 0;
  int samples_checked = 0;

  sbdc_remote_model #(.LAT(2)) remote (
    .i_clk(clk), .i_ch1(rm_ch1), .i_ch2(rm_ch2), .i_trip(rm_trip),
    .o_ch1(ch1), .o_ch2(ch2), .o_rx_trip(rx)
  );
  sbdc_stub_diff uut (
    .I_REF_CLK(clk), .I_RESET(rst), .I_AVS_ADDRESS(adr), .I_AVS_READ(rd_s),
    .I_AVS_WRITE(wr_s), .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(4'hF),
    .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq),
    .I_LINE_SWITCH_OPEN(sw), .I_STUB_TRIGGER(trig), .I_DIFF_INHIBIT(inh),
    .I_EXTRA_REMOTE_TRIP_KEY(key), .I_RX_REMOTE_TRIP_COMMAND(rx),
    .I_LOCAL_CURRENT(loc), .I_CH1_CURRENT(ch1), .I_CH2_CURRENT(ch2),
    .O_STUB_OPERATE(op), .O_TX_CURRENT(txc), .O_CH1_SCALED(s1), .O_CH2_SCALED(s2),
    .O_DIFF_TRIP(dtrip), .O_TX_REMOTE_TRIP_COMMAND(ttrip),
    .O_RX_TRIP_ACCEPTED(racc), .O_ACTIVE_GROUP(grp)
  );

  initial
  begin
    forever #50 clk = ~clk;
  end

  // ==========================================================
  // shared tasks
  task automatic results;
    if (n_fail == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // request held until waitrequest is sampled low; no fixed latency assumed
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wr_s <= w;
    rd_s <= !w;
    wd <= d;
    @(posedge clk);
    while (waitreq !== 1'b0 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    q = rdata;
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    if (n >= 50)
    begin
      n_fail++;
      results();
    end
  endtask : bus

  // pins pass a synchroniser and the remote link, so allow eight edges
  task automatic settle;
    repeat (8) @(posedge clk);
  endtask : settle

  // ==========================================================
  // scenarios
  task automatic t_regs;
    bus(0, 8'h00, 0); check(48'(q), 48'h0);
    bus(0, 8'h80, 0); check(48'(q), 48'(sbdc_pkg::W0_RST));
    bus(0, 8'hF4, 0); check(48'(q), 48'(sbdc_pkg::W1_RST));
    bus(0, 8'h88, 0); check(48'(q), 48'(sbdc_pkg::W2_RST));
    bus(0, 8'h8C, 0); check(48'(q), 48'h0);
    bus(0, 8'h40, 0); check(48'(q), 48'h0);
    bus(1, 8'h04, 32'hFFFF_FFFF);
    bus(0, 8'h04, 0); check(48'(q), 48'h0);
  endtask : t_regs

  task automatic t_groups;
    for (int g = 0; g < 8; g++)
      bus(1, 8'(8'h80 + g * 16), {16'(g + 1), 16'h0000});
    for (int g = 0; g < 8; g++)
    begin
      bus(1, 8'h00, 32'(g + 1));
      settle();
      check(48'(grp), 48'(g));
      bus(0, 8'(8'h80 + g * 16), 0); check(48'(q), 48'({16'(g + 1), 16'h0000}));
      bus(0, 8'h04, 0); check(48'(q[12:10]), 48'(g));
    end
    bus(1, 8'h00, 32'h9);
    settle();
    check(48'(grp), 48'h0);
    bus(1, 8'h00, 32'h0);
    settle();
    check(48'(grp), 48'h0);
  endtask : t_groups

  task automatic t_stub;
    bus(1, 8'h80, 32'h0040_0007);
    loc <= {16'h0010, 16'h0100, 16'h0100};
    rm_trip <= 3'h5;
    sw <= 1'b1;
    settle();
    check(48'(op), 48'h0); check(txc, loc); check(48'(racc), 48'h5);
    trig <= 1'b1;
    settle();
    check(48'(op), 48'h1); check(txc, 48'h0);
    check(48'(racc), 48'h0); check(48'(dtrip), 48'h0);
    trig <= 1'b0;
    settle();
    check(48'(op), 48'h0); check(txc, loc); check(48'(racc), 48'h5);
    sw <= 1'b0;
    bus(1, 8'h80, 32'h0040_000F);
    sw <= 1'b1;
    settle();
    check(48'(op), 48'h1);
    sw <= 1'b0;
    settle();
    check(48'(op), 48'h0);
    bus(1, 8'h80, 32'h0040_000D);
    sw <= 1'b1;
    settle();
    check(48'(op), 48'h0);
    sw <= 1'b0;
    rm_trip <= 3'h0;
  endtask : t_stub

  task automatic t_diff;
    bus(1, 8'h80, 32'h0040_0005);
    settle();
    check(48'(dtrip), 48'h3); check(48'(ttrip), 48'h3);
    inh <= 1'b1;
    settle();
    check(48'(dtrip), 48'h0);
    inh <= 1'b0;
    bus(1, 8'h80, 32'h0040_0001);
    settle();
    check(48'(dtrip), 48'h3); check(48'(ttrip), 48'h0);
    key <= 1'b1;
    settle();
    check(48'(ttrip), 48'h7);
    key <= 1'b0;
    bus(1, 8'h80, 32'h0040_0004);
    settle();
    check(48'(dtrip), 48'h0);
    // second slope: restraint past the breakpoint holds this one off
    bus(1, 8'h80, 32'h0040_0001);
    loc <= {32'h0, 16'h0400};
    rm_ch1 <= {32'h0, 16'hFD00};
    settle();
    check(48'(dtrip), 48'h0);
    rm_ch1 <= {32'h0, 16'hFF00};
    settle();
    check(48'(dtrip), 48'h1);
    bus(1, 8'h84, 32'h0100_0200);
    rm_ch1 <= {32'h0, 16'h0100};
    rm_ch2 <= {32'h0, 16'h0100};
    settle();
    check(s1, {32'h0, 16'h0200}); check(s2, {32'h0, 16'h0100});
  endtask : t_diff

  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_groups();
    t_stub();
    t_diff();
    results();
  end
endmodule : sbdc_stub_diff_tb

`default_nettype wire
